// ### acr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Serial host model; the data line has a pull-up, so a released line reads high.
module acr_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic pull_o
);
    logic [7:0] rx; // Last byte read back from the device.
    event got; // Fires once for every byte read back.
    // Lines change only at the falling system edge, far from the device's sampling.
    task automatic q();
        repeat (4) @(negedge clk_i);
    endtask : q
    // One bit: data is set while the clock is low and held through the high phase.
    task automatic bit_x(input logic b, output logic r);
        pull_o = !b;
        q();
        scl_o = 1'b1;
        q();
        r = sda_i;
        q();
        scl_o = 1'b0;
        q();
    endtask : bit_x
    // Eight bits most significant first, then the acknowledge bit.
    task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(nak, a);
    endtask : xfer
    // Start, or repeated start, while the clock is high.
    task automatic start();
        pull_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        pull_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask : start
    // Stop: data rises while the clock is high.
    task automatic stop();
        pull_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        pull_o = 1'b0;
        q();
    endtask : stop
    // Sets the register pointer; the write bit follows the address.
    task automatic point(input logic [7:0] a);
        start();
        xfer({acr_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx);
        xfer(a, 1'b1, rx);
    endtask : point
    // Single byte write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        point(a);
        xfer(d, 1'b1, rx);
        stop();
    endtask : wr
    // Burst read; the last byte is refused so the device lets go of the line.
    task automatic rd(input logic [7:0] a, input int n);
        point(a);
        start();
        xfer({acr_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, rx);
            -> got;
        end
        stop();
    endtask : rd
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
endmodule : acr_host
`default_nettype wire

// ### acr_pkg.sv
package acr_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] X_AXIS_LOW_BYTE = 8'h06;
    localparam logic [7:0] X_AXIS_HIGH_BYTE = 8'h07;
    localparam logic [7:0] Y_AXIS_LOW_BYTE = 8'h08;
    localparam logic [7:0] Y_AXIS_HIGH_BYTE = 8'h09;
    localparam logic [7:0] Z_AXIS_LOW_BYTE = 8'h0a;
    localparam logic [7:0] Z_AXIS_HIGH_BYTE = 8'h0b;
    localparam logic [7:0] COMM_SELFTEST_RESPONSE = 8'h0c;
    localparam logic [7:0] SUPPLIER_IDENTIFICATION = 8'h0f;
    localparam logic [7:0] EVENT_SOURCE_PRIMARY = 8'h16;
    localparam logic [7:0] MOTION_DIRECTION_SOURCE = 8'h17;
    localparam logic [7:0] COMBINED_EVENT_STATUS = 8'h18;
    localparam logic [7:0] EVENT_RELEASE = 8'h1a;
    localparam logic [7:0] MAIN_CONTROL = 8'h1b;
    localparam logic [7:0] SELFTEST_CONTROL = 8'h1d;
    localparam logic [7:0] INT_PIN_CONTROL = 8'h1e;

    // Field positions in the main control register.
    localparam int POWER_STATE_SELECT = 7;
    localparam int RESOLUTION_SELECT = 6;
    localparam int NEW_SAMPLE_IRQ_ENABLE = 5;
    localparam int RANGE_SELECT_HIGH = 4;
    localparam int RANGE_SELECT_LOW = 3;
    localparam int MOTION_WAKE_ENABLE = 1;
    localparam logic [7:0] MAIN_CONTROL_MASK = 8'hfa;
    localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;

    // Field positions in the source, status, self-test and pin control registers.
    localparam int NEW_SAMPLE_FLAG = 4;
    localparam int MOTION_WAKE_FLAG = 1;
    localparam int STATUS_INT_BIT = 4;
    localparam int COMM_SELFTEST_TRIGGER = 4;
    localparam int IRQ_PIN_ENABLE = 5;
    localparam int IRQ_ACTIVE_HIGH = 4;
    localparam int IRQ_PULSE_SELECT = 3;
    localparam logic [7:0] INT_PIN_CONTROL_MASK = 8'h38;
    localparam logic [7:0] INT_PIN_CONTROL_RESET = 8'h10;

    // Range code that selects the fourteen bit variant.
    localparam logic [1:0] RANGE_8G_HIRES = 2'h3;

    // Self-test response values.
    localparam logic [7:0] SELFTEST_IDLE = 8'h55;
    localparam logic [7:0] SELFTEST_ACTIVE = 8'haa;

    // Arbitrary identification and bus address values.
    localparam logic [7:0] ID_DEFAULT = 8'h5a;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h0e;

    // Interrupt pulse width, shortest allowed figure, rounded up.
    localparam int CLK_MHZ = 100;
    localparam int PULSE_MIN_NS = 30000;
    localparam int PULSE_MAX_NS = 50000;
    localparam logic [11:0] PULSE_CYC = 12'((PULSE_MIN_NS * CLK_MHZ + 999) / 1000);

    // Serial slave states.
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_REG = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WR = 9'h020,
        ST_WR_ACK = 9'h040,
        ST_RD = 9'h080,
        ST_RD_ACK = 9'h100
    } acr_state_e;

endpackage : acr_pkg

// ### acr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - X result split over high and low bytes.
// - Y result uses the same split layout.
// - Z result uses the same split layout.
// - Self-test response 0x55, 0xAA when triggered.
// - Read-only identification byte register.
// - Sources latch until a release read, or for the new-sample flag a data read.
// - Unlatched reporting mode via interrupt control.
// - New-sample flag clears on data or release.
// - Motion flag clears only on release read.
// - Direction bits report motion axis and sign.
// - Status bit sets on either source event, clears on data or release read.
// - Release read clears sources, and the pin in latched mode only.
// - Control bit 7 selects stand-by or operating.
// - Control bit 6 selects eight or twelve bits.
// - Control bit 5 gates new-sample interrupts.
// - Control bits 4:3 select measurement range.
// - Control bit 1 enables motion wake-up.
// - Control resets zero, bits 2 and 0 zero.
// - Axis data is two's complement.
// - Fourteen bit mode only high-res range 11.
// - Self-test trigger clears on response read.
// - Pulsed mode emits one 30-50 us pulse.
module acr_regs #(
    parameter logic [6:0] DEV_ADDR = acr_pkg::DEV_ADDR_DEFAULT, // Bus address, arbitrary.
    parameter logic [7:0] ID_VALUE = acr_pkg::ID_DEFAULT, // Identification, arbitrary.
    parameter logic [11:0] PULSE_LEN = acr_pkg::PULSE_CYC // Interrupt pulse in cycles.
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic SAMPLE_VALID_I,
    input wire logic [13:0] SAMPLE_X_I,
    input wire logic [13:0] SAMPLE_Y_I,
    input wire logic [13:0] SAMPLE_Z_I,
    input wire logic MOTION_I,
    input wire logic [5:0] MOTION_DIR_I,
    output logic INT_O,
    output logic POWER_ON_O,
    output logic RESOLUTION_O,
    output logic [1:0] RANGE_O,
    output logic WAKE_EN_O
);
    import acr_pkg::*;

    logic scl_m, scl_s, scl_d; // Clock synchroniser and its delayed copy.
    logic sda_m, sda_s, sda_d; // Data synchroniser and its delayed copy.
    logic scl_rise, scl_fall, bus_start, bus_stop; // Decoded line events.
    acr_state_e state; // Serial slave state.
    logic [7:0] shift; // Shift register for both directions.
    logic [2:0] bitcnt; // Bit counter within a byte.
    logic got_byte; // A whole byte has been shifted in.
    logic rw; // Direction bit of the current transfer.
    logic nack; // Host refused the last read byte.
    logic [7:0] ptr; // Register pointer, auto-incrementing.
    logic rd_stb; // One-cycle pulse when a byte is read.
    logic [7:0] rd_addr; // Address of that read.
    logic wr_stb; // One-cycle pulse when a byte is written.
    logic [7:0] rd_byte; // Read data for the pointer.
    logic [7:0] ctrl; // Main control register.
    logic [7:0] pin_ctrl; // Interrupt pin control register.
    logic trig; // Communication self-test trigger.
    logic [13:0] x_q, y_q, z_q; // Held axis samples.
    logic new_sample_flag, motion_wake_flag, status_int; // Source and status flags.
    logic [5:0] dir_q; // Motion direction source bits.
    logic [11:0] pulse_cnt; // Remaining pulse length.
    logic new_sample_flag_set, wake_set, axis_read, rel_read; // Event terms.
    logic res14; // Fourteen bit output mode.

    // Line samples pass two flops; the third copy only serves edge detection.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else if (CE_I) begin
            {scl_m, scl_s, scl_d} <= {SCL_I, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {SDA_I, sda_m, sda_s};
        end
    end

    // Start and stop are data changes while the clock is high.
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // Event terms shared by the flag processes.
    assign new_sample_flag_set = SAMPLE_VALID_I & ctrl[POWER_STATE_SELECT]
        & ctrl[NEW_SAMPLE_IRQ_ENABLE];
    assign wake_set = MOTION_I & ctrl[POWER_STATE_SELECT] & ctrl[MOTION_WAKE_ENABLE];
    assign axis_read = rd_stb & (rd_addr >= X_AXIS_LOW_BYTE) & (rd_addr <= Z_AXIS_HIGH_BYTE);
    assign rel_read = rd_stb & (rd_addr == EVENT_RELEASE);
    assign res14 = ctrl[RESOLUTION_SELECT]
        & (ctrl[RANGE_SELECT_HIGH:RANGE_SELECT_LOW] == RANGE_8G_HIRES);

    // Low byte: left-justified remainder of the sample; unused bits read zero.
    function automatic logic [7:0] low_byte(input logic [13:0] s, input logic hi, input logic f14);
        if (!hi) begin
            low_byte = 8'h00; // Eight bit mode carries everything in the high byte.
        end else if (f14) begin
            low_byte = {s[5:0], 2'h0};
        end else begin
            low_byte = {s[5:2], 4'h0};
        end
    endfunction : low_byte

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rd_byte = 8'h00;
        case (ptr)
            X_AXIS_LOW_BYTE: rd_byte = low_byte(x_q, ctrl[RESOLUTION_SELECT], res14);
            X_AXIS_HIGH_BYTE: rd_byte = x_q[13:6];
            Y_AXIS_LOW_BYTE: rd_byte = low_byte(y_q, ctrl[RESOLUTION_SELECT], res14);
            Y_AXIS_HIGH_BYTE: rd_byte = y_q[13:6];
            Z_AXIS_LOW_BYTE: rd_byte = low_byte(z_q, ctrl[RESOLUTION_SELECT], res14);
            Z_AXIS_HIGH_BYTE: rd_byte = z_q[13:6];
            COMM_SELFTEST_RESPONSE: rd_byte = trig ? SELFTEST_ACTIVE : SELFTEST_IDLE;
            SUPPLIER_IDENTIFICATION: rd_byte = ID_VALUE;
            EVENT_SOURCE_PRIMARY: begin
                rd_byte[NEW_SAMPLE_FLAG] = new_sample_flag;
                rd_byte[MOTION_WAKE_FLAG] = motion_wake_flag;
            end
            MOTION_DIRECTION_SOURCE: rd_byte = {2'h0, dir_q};
            COMBINED_EVENT_STATUS: rd_byte[STATUS_INT_BIT] = status_int;
            MAIN_CONTROL: rd_byte = ctrl;
            SELFTEST_CONTROL: rd_byte[COMM_SELFTEST_TRIGGER] = trig;
            INT_PIN_CONTROL: rd_byte = pin_ctrl;
            default: rd_byte = 8'h00; // The release register reads zero.
        endcase
    end

    // Serial slave. Data is sampled on clock rise and changed on clock fall.
    // Start or stop take precedence over any bit activity in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bitcnt <= 3'h0;
            got_byte <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            ptr <= 8'h00;
            rd_stb <= 1'b0;
            rd_addr <= 8'h00;
            wr_stb <= 1'b0;
            SDA_OE_O <= 1'b0;
            SDA_O <= 1'b0;
        end else if (CE_I) begin
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            if (bus_start) begin
                state <= ST_ADDR;
                bitcnt <= 3'h0;
                got_byte <= 1'b0;
                SDA_OE_O <= 1'b0;
            end else if (bus_stop) begin
                state <= ST_IDLE;
                SDA_OE_O <= 1'b0;
            end else if (scl_rise) begin
                // Receiving states shift in; the read acknowledge slot is sampled.
                if (state == ST_ADDR || state == ST_REG || state == ST_WR) begin
                    shift <= {shift[6:0], sda_s};
                    bitcnt <= bitcnt + 3'h1;
                    got_byte <= (bitcnt == 3'h7);
                end else if (state == ST_RD_ACK) begin
                    nack <= sda_s;
                end
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (got_byte) begin
                            got_byte <= 1'b0;
                            if (shift[7:1] == DEV_ADDR) begin
                                rw <= shift[0];
                                SDA_OE_O <= 1'b1; // Acknowledge our address.
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IDLE; // Another slave is addressed.
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_RD_ACK: begin
                        if (state == ST_ADDR_ACK && !rw) begin
                            SDA_OE_O <= 1'b0;
                            state <= ST_REG;
                        end else if (state == ST_RD_ACK && nack) begin
                            SDA_OE_O <= 1'b0;
                            state <= ST_IDLE; // Host ended the read.
                        end else begin
                            // Load the byte; its read side effects fire now.
                            shift <= rd_byte;
                            SDA_OE_O <= ~rd_byte[7];
                            rd_stb <= 1'b1;
                            rd_addr <= ptr;
                            ptr <= ptr + 8'h01;
                            bitcnt <= 3'h0;
                            state <= ST_RD;
                        end
                    end
                    ST_REG: begin
                        if (got_byte) begin
                            got_byte <= 1'b0;
                            ptr <= shift;
                            SDA_OE_O <= 1'b1;
                            state <= ST_REG_ACK;
                        end
                    end
                    ST_WR: begin
                        if (got_byte) begin
                            got_byte <= 1'b0;
                            wr_stb <= 1'b1;
                            SDA_OE_O <= 1'b1;
                            state <= ST_WR_ACK;
                        end
                    end
                    ST_REG_ACK, ST_WR_ACK: begin
                        SDA_OE_O <= 1'b0;
                        bitcnt <= 3'h0;
                        if (state == ST_WR_ACK) begin
                            ptr <= ptr + 8'h01;
                        end
                        state <= ST_WR;
                    end
                    ST_RD: begin
                        if (bitcnt == 3'h7) begin
                            SDA_OE_O <= 1'b0; // Free the line for the host.
                            state <= ST_RD_ACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            SDA_OE_O <= ~shift[6];
                            bitcnt <= bitcnt + 3'h1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Control registers. Fields other than the power bit are stored as written;
    // the host is trusted to enter stand-by first, so no write is blocked.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ctrl <= MAIN_CONTROL_RESET;
            pin_ctrl <= INT_PIN_CONTROL_RESET;
        end else if (CE_I && wr_stb) begin
            if (ptr == MAIN_CONTROL) begin
                ctrl <= shift & MAIN_CONTROL_MASK;
            end
            if (ptr == INT_PIN_CONTROL) begin
                pin_ctrl <= shift & INT_PIN_CONTROL_MASK;
            end
        end
    end

    // Self-test trigger: set by write, cleared by reading the response.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            trig <= 1'b0;
        end else if (CE_I) begin
            if (wr_stb && ptr == SELFTEST_CONTROL && shift[COMM_SELFTEST_TRIGGER]) begin
                trig <= 1'b1;
            end else if (rd_stb && rd_addr == COMM_SELFTEST_RESPONSE) begin
                trig <= 1'b0;
            end
        end
    end

    // Axis samples are two's complement and captured only while operating.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            x_q <= 14'h0000;
            y_q <= 14'h0000;
            z_q <= 14'h0000;
        end else if (CE_I && SAMPLE_VALID_I && ctrl[POWER_STATE_SELECT]) begin
            x_q <= SAMPLE_X_I;
            y_q <= SAMPLE_Y_I;
            z_q <= SAMPLE_Z_I;
        end
    end

    // Source and status flags. A new event in the clearing cycle wins.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            new_sample_flag <= 1'b0;
            motion_wake_flag <= 1'b0;
            status_int <= 1'b0;
            dir_q <= 6'h00;
        end else if (CE_I) begin
            new_sample_flag <= new_sample_flag_set | (new_sample_flag & ~axis_read & ~rel_read);
            motion_wake_flag <= wake_set | (motion_wake_flag & ~rel_read);
            status_int <= new_sample_flag_set | wake_set
                | (status_int & ~axis_read & ~rel_read);
            if (wake_set && pin_ctrl[IRQ_PULSE_SELECT]) begin
                dir_q <= MOTION_DIR_I; // Unlatched: each event replaces the last.
            end else if (wake_set) begin
                dir_q <= MOTION_DIR_I | (rel_read ? 6'h00 : dir_q);
            end else if (rel_read) begin
                dir_q <= 6'h00;
            end
        end
    end

    // Pulse timer for the unlatched pin mode.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            pulse_cnt <= 12'h000;
        end else if (CE_I) begin
            if ((new_sample_flag_set || wake_set) && pin_ctrl[IRQ_PULSE_SELECT]) begin
                pulse_cnt <= PULSE_LEN;
            end else if (pulse_cnt != 12'h000) begin
                pulse_cnt <= pulse_cnt - 12'h001;
            end
        end
    end

    // Pin and mode outputs. A disabled pin rests at its inactive level.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            INT_O <= 1'b0;
            POWER_ON_O <= 1'b0;
            RESOLUTION_O <= 1'b0;
            RANGE_O <= 2'h0;
            WAKE_EN_O <= 1'b0;
        end else if (CE_I) begin
            if (pin_ctrl[IRQ_PIN_ENABLE] && (pin_ctrl[IRQ_PULSE_SELECT]
                    ? (pulse_cnt != 12'h000) : status_int)) begin
                INT_O <= pin_ctrl[IRQ_ACTIVE_HIGH];
            end else begin
                INT_O <= ~pin_ctrl[IRQ_ACTIVE_HIGH];
            end
            POWER_ON_O <= ctrl[POWER_STATE_SELECT];
            RESOLUTION_O <= ctrl[RESOLUTION_SELECT];
            RANGE_O <= ctrl[RANGE_SELECT_HIGH:RANGE_SELECT_LOW];
            WAKE_EN_O <= ctrl[MOTION_WAKE_ENABLE];
        end
    end

    // Checks that tie flags and outputs to their causes.
    AST_CTRL_FIXED_ZERO: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        ctrl[2] == 1'b0 && ctrl[0] == 1'b0)
        else $error("Fixed-zero control bits are set.");

    AST_SELFTEST_READ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && rd_stb && rd_addr == COMM_SELFTEST_RESPONSE |=> !trig)
        else $error("Self-test trigger survived a response read.");

    AST_RELEASE_CLEARS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && rel_read && !new_sample_flag_set && !wake_set |=> !new_sample_flag && !motion_wake_flag && !status_int)
        else $error("Release read left a source flag set.");

    AST_AXIS_READ_CLEARS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && axis_read && !new_sample_flag_set |=> !new_sample_flag)
        else $error("Axis read did not clear the new-sample flag.");

    AST_WAKE_HOLDS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && motion_wake_flag && !rel_read |=> motion_wake_flag)
        else $error("Motion flag dropped without a release read.");

    AST_STATUS_FOLLOWS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && (new_sample_flag_set || wake_set) |=> status_int && (new_sample_flag || motion_wake_flag))
        else $error("Status bit did not follow a source event.");

    AST_NO_NEW_SAMPLE_FLAG_DISABLED: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && !ctrl[NEW_SAMPLE_IRQ_ENABLE] && !new_sample_flag |=> !new_sample_flag)
        else $error("New-sample flag set while its enable is off.");

    AST_PULSE_LOAD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && wake_set && pin_ctrl[IRQ_PULSE_SELECT] |=> pulse_cnt == PULSE_LEN)
        else $error("Pulse timer not loaded with the pulse length.");

    AST_X_HIGH_BYTE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        ptr == X_AXIS_HIGH_BYTE |-> rd_byte == x_q[13:6])
        else $error("X high byte does not carry the upper sample bits.");

    AST_LOW_NIBBLE_ZERO: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        ptr == Y_AXIS_LOW_BYTE && !res14 |-> rd_byte[3:0] == 4'h0)
        else $error("Unused low-byte bits read non-zero.");

    AST_POWER_OUT: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        CE_I && wr_stb && ptr == MAIN_CONTROL |=> ##1 POWER_ON_O == $past(shift[7], 2))
        else $error("Power output does not follow the written control bit.");

endmodule : acr_regs

`default_nettype wire

// ### acr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench; expected read bytes wait in a queue for the monitor.
module acr_regs_test;
    import acr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic vld = 1'b0;
    logic ce = 1'b1;
    logic mot = 1'b0;
    logic [5:0] dir = 6'h00;
    logic [13:0] smp [3] = '{14'h0000, 14'h0000, 14'h0000};
    logic sda_oe, sda_o, int_o, pwr, res, wake, scl, pull;
    logic [1:0] rng;
    wire sda = !(pull || (sda_oe && !sda_o)); // Open drain with pull-up.
    int num_errors = 0;
    int n_tests = 0;
    int seed = 28521;
    logic [7:0] q_exp [$];
    always #5 clk = ~clk;
    acr_regs #(.PULSE_LEN(12'd20)) DUT (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .SAMPLE_VALID_I(vld), .SAMPLE_X_I(smp[0]), .SAMPLE_Y_I(smp[1]),
        .SAMPLE_Z_I(smp[2]), .MOTION_I(mot), .MOTION_DIR_I(dir), .INT_O(int_o),
        .POWER_ON_O(pwr), .RESOLUTION_O(res), .RANGE_O(rng), .WAKE_EN_O(wake));
    acr_host h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] w);
        q_exp.push_back(w);
        h.rd(a, 1);
    endtask : rd
    // New random sample, one cycle strobe.
    task automatic sample();
        foreach (smp[i]) smp[i] = 14'($random(seed));
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
    endtask : sample
    // One-cycle motion event with the given direction bits.
    task automatic motion(input logic [5:0] d);
        dir = d;
        mot = 1'b1;
        @(negedge clk);
        mot = 1'b0;
    endtask : motion
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // Release reads return zero but are not checked, so no note is queued for them.
    always @(h.got) begin
        if (q_exp.size() > 0) chk(h.rx, q_exp.pop_front());
    end
    initial begin
        #500us;
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        rd(MAIN_CONTROL, 8'h00);
        rd(COMM_SELFTEST_RESPONSE, SELFTEST_IDLE);
        rd(SUPPLIER_IDENTIFICATION, ID_DEFAULT);
        rd(8'h10, 8'h00);
        $display("reset values done");
        h.wr(MAIN_CONTROL, 8'hff);
        rd(MAIN_CONTROL, 8'hfa);
        chk({pwr, res, rng, wake, 3'h0}, 8'hf8);
        h.wr(MAIN_CONTROL, 8'h7a);
        for (int g = 0; g < 4; g++) begin
            h.wr(MAIN_CONTROL, 8'(g << 3));
            chk({6'h00, rng}, 8'(g));
        end
        h.wr(INT_PIN_CONTROL, 8'h30);
        h.wr(MAIN_CONTROL, 8'h62);
        h.wr(MAIN_CONTROL, 8'he2);
        sample();
        rd(EVENT_SOURCE_PRIMARY, 8'h10);
        rd(COMBINED_EVENT_STATUS, 8'h10);
        chk({7'h00, int_o}, 8'h01);
        foreach (smp[i]) begin
            q_exp.push_back({smp[i][5:2], 4'h0});
            q_exp.push_back(smp[i][13:6]);
        end
        for (int i = 0; i < 3; i++) h.rd(8'(X_AXIS_LOW_BYTE + 2 * i), 2);
        rd(COMBINED_EVENT_STATUS, 8'h00);
        $display("sample done");
        motion(6'($random(seed)) | 6'h01);
        rd(MOTION_DIRECTION_SOURCE, {2'h0, dir});
        rd(EVENT_SOURCE_PRIMARY, 8'h02);
        chk({7'h00, int_o}, 8'h01);
        h.wr(INT_PIN_CONTROL, 8'h38);
        motion(~dir);
        @(negedge clk);
        chk({7'h00, int_o}, 8'h01);
        repeat (25) @(negedge clk);
        chk({7'h00, int_o}, 8'h00);
        rd(MOTION_DIRECTION_SOURCE, {2'h0, dir});
        h.wr(INT_PIN_CONTROL, 8'h30);
        h.rd(EVENT_RELEASE, 1);
        rd(EVENT_SOURCE_PRIMARY, 8'h00);
        rd(MOTION_DIRECTION_SOURCE, 8'h00);
        chk({7'h00, int_o}, 8'h00);
        rd(Z_AXIS_HIGH_BYTE, smp[2][13:6]);
        $display("motion done");
        h.wr(SELFTEST_CONTROL, 8'h10);
        rd(COMM_SELFTEST_RESPONSE, SELFTEST_ACTIVE);
        rd(COMM_SELFTEST_RESPONSE, SELFTEST_IDLE);
        rd(SELFTEST_CONTROL, 8'h00);
        h.wr(MAIN_CONTROL, 8'h62);
        h.wr(MAIN_CONTROL, 8'h00);
        h.wr(MAIN_CONTROL, 8'h80);
        sample();
        rd(EVENT_SOURCE_PRIMARY, 8'h00);
        rd(X_AXIS_LOW_BYTE, 8'h00);
        $display("self-test and low resolution done");
        h.wr(MAIN_CONTROL, 8'h00);
        h.wr(MAIN_CONTROL, 8'h58);
        h.wr(MAIN_CONTROL, 8'hd8);
        sample();
        repeat (2) q_exp.push_back({smp[0][5:0], 2'h0});
        h.rd(X_AXIS_LOW_BYTE, 1);
        ce = 1'b0;
        sample();
        ce = 1'b1;
        h.rd(X_AXIS_LOW_BYTE, 1);
        $display("fourteen bit and clock enable done");
        finish_test();
    end
endmodule : acr_regs_test
`default_nettype wire
